// file: rtl/csss_pkg.sv
// types shared by the scan start selector
package csss_pkg;

  // ==================================================
  // start of conversion mode codes
  typedef enum logic [2:0] {
    CSSS_MODE_SW = 3'b000,
    CSSS_MODE_T0 = 3'b001,
    CSSS_MODE_T2 = 3'b010,
    CSSS_MODE_T1 = 3'b011,
    CSSS_MODE_T3 = 3'b100,
    CSSS_MODE_SINGLE_SCAN = 3'b101,
    CSSS_MODE_CONT_MUX = 3'b110,
    CSSS_MODE_CONT_RANGE = 3'b111
  } csss_mode_t;

  // ==================================================
  // configuration register layout
  typedef struct packed {
    logic scan_mask_enable;
    csss_mode_t start_mode_select;
    logic multi_chan_enable;
    logic [2:0] accum_select;
  } csss_config_t;

  // ==================================================
  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csss_bus_req_t;

  // ==================================================
  // sequencer states
  typedef enum logic [0:0] {
    CSSS_ST_IDLE = 1'b0,
    CSSS_ST_CONV = 1'b1
  } csss_state_t;

endpackage

// file: rtl/csss_regs.svh
// register offsets, field positions and reset values for the scan start selector
//
// Overview of operation
// - masking off ignores both channel mask registers
// - masking on in modes 101 and 111 scans only mask-selected channels
// - mode 000 starts on busy-bit write
// - mode 001 starts on timer 0 overflow
// - mode 010 starts on timer 2 overflow
// - mode 011 starts on timer 1 overflow
// - mode 100 starts on timer 3 overflow
// - mode 110 repeats on mux-selected channel
// - mode 111 unmasked steps first to last
// - masked mode 101 does one scan pass
// - masked mode 111 scans mask channels forever
// - busy write one starts only allowed modes
`ifndef CSSS_REGS_SVH
`define CSSS_REGS_SVH

// ==================================================
// register offsets
`define CSSS_OFS_CONFIG 3'h0
`define CSSS_OFS_CONTROL 3'h1
`define CSSS_OFS_MASK_LOW 3'h2
`define CSSS_OFS_MASK_HIGH 3'h3
`define CSSS_OFS_MUX_SELECT 3'h4
`define CSSS_OFS_SCAN_FIRST 3'h5
`define CSSS_OFS_SCAN_LAST 3'h6

// ==================================================
// field positions
`define CSSS_BUSY_BIT 4
`define CSSS_CHAN_MSB 3

// ==================================================
// reset values
`define CSSS_RST_CONFIG 8'h00
`define CSSS_RST_MASK 8'h00
`define CSSS_RST_CHAN 4'h0
`define CSSS_RST_RDATA 8'h00

`endif

// file: rtl/csss_top.sv
// start source and scan channel selection for the capacitive sense converter
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "csss_regs.svh"

module csss_top #(
  parameter int NUM_CH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire csss_pkg::csss_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // timer overflow pulses, index is timer number
  input wire logic [3:0] timer_ovf,
  // converter handshake
  input wire logic conv_done,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic conv_busy
);
  import csss_pkg::*;

  // ==================================================
  // reset synchroniser
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==================================================
  // configuration registers
  csss_config_t config_reg;
  logic [7:0] mask_low_reg;
  logic [7:0] mask_high_reg;
  logic [3:0] mux_select_reg;
  logic [3:0] scan_first_reg;
  logic [3:0] scan_last_reg;
  logic wr_config;
  logic wr_control;

  assign wr_config = bus_req.wr && (bus_req.addr == `CSSS_OFS_CONFIG);
  assign wr_control = bus_req.wr && (bus_req.addr == `CSSS_OFS_CONTROL);

  // bit 3 of the configuration is read-only and stays zero
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      config_reg <= `CSSS_RST_CONFIG;
    end
    else if (wr_config)
    begin
      config_reg.scan_mask_enable <= bus_req.wdata[7];
      config_reg.start_mode_select <= csss_mode_t'(bus_req.wdata[6:4]);
      config_reg.accum_select <= bus_req.wdata[2:0];
    end
  end

  // ==================================================
  // channel mask registers, low byte holds channels 7..0
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      mask_low_reg <= `CSSS_RST_MASK;
      mask_high_reg <= `CSSS_RST_MASK;
    end
    else if (bus_req.wr && (bus_req.addr == `CSSS_OFS_MASK_LOW))
    begin
      mask_low_reg <= bus_req.wdata;
    end
    else if (bus_req.wr && (bus_req.addr == `CSSS_OFS_MASK_HIGH))
    begin
      mask_high_reg <= bus_req.wdata;
    end
  end

  // ==================================================
  // channel selects for the mux and the range scan
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      mux_select_reg <= `CSSS_RST_CHAN;
      scan_first_reg <= `CSSS_RST_CHAN;
      scan_last_reg <= `CSSS_RST_CHAN;
    end
    else if (bus_req.wr && (bus_req.addr == `CSSS_OFS_MUX_SELECT))
    begin
      mux_select_reg <= bus_req.wdata[`CSSS_CHAN_MSB:0];
    end
    else if (bus_req.wr && (bus_req.addr == `CSSS_OFS_SCAN_FIRST))
    begin
      scan_first_reg <= bus_req.wdata[`CSSS_CHAN_MSB:0];
    end
    else if (bus_req.wr && (bus_req.addr == `CSSS_OFS_SCAN_LAST))
    begin
      scan_last_reg <= bus_req.wdata[`CSSS_CHAN_MSB:0];
    end
  end

  // ==================================================
  // effective channel mask
  logic [15:0] chan_mask;
  logic masking;
  csss_mode_t mode;

  assign masking = config_reg.scan_mask_enable;
  assign mode = config_reg.start_mode_select;
  // upper channels beyond NUM_CH are never selected by the mask scans; mux select and scan range are not limited
  assign chan_mask = {mask_high_reg, mask_low_reg} & 16'((17'h1 << NUM_CH) - 17'h1);

  // lowest masked channel at or above a starting point
  function automatic logic [4:0] find_masked(input logic [15:0] mask, input logic [4:0] from);
    logic [4:0] res;
    res = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (mask[i] && (5'(i) >= from))
      begin
        res = 5'(i);
      end
    end
    return res;
  endfunction

  // ==================================================
  // start source decode
  logic sw_start;
  logic trigger;
  logic reserved_mode;

  assign sw_start = wr_control && bus_req.wdata[`CSSS_BUSY_BIT];
  assign reserved_mode = !masking && (mode == CSSS_MODE_SINGLE_SCAN);

  always_comb
  begin
    trigger = 1'b0;
    unique case (mode)
      CSSS_MODE_SW: trigger = sw_start;
      CSSS_MODE_T0: trigger = timer_ovf[0];
      CSSS_MODE_T2: trigger = timer_ovf[2];
      CSSS_MODE_T1: trigger = timer_ovf[1];
      CSSS_MODE_T3: trigger = timer_ovf[3];
      CSSS_MODE_SINGLE_SCAN: trigger = sw_start && !reserved_mode;
      CSSS_MODE_CONT_MUX: trigger = sw_start;
      CSSS_MODE_CONT_RANGE: trigger = sw_start;
    endcase
  end

  // ==================================================
  // channel for the first conversion of a run
  csss_state_t state_reg;
  logic conv_start_reg;
  logic [3:0] conv_channel_reg;
  logic [4:0] first_masked;
  logic [4:0] next_masked;
  logic [4:0] wrap_masked;
  logic scan_mode;
  logic first_ok;
  logic [3:0] first_chan;

  assign scan_mode = masking && ((mode == CSSS_MODE_SINGLE_SCAN) || (mode == CSSS_MODE_CONT_RANGE));
  assign first_masked = find_masked(chan_mask, 5'h00);
  assign next_masked = find_masked(chan_mask, {1'b0, conv_channel_reg} + 5'h01);
  assign wrap_masked = next_masked[4] ? first_masked : next_masked;

  always_comb
  begin
    first_ok = 1'b1;
    first_chan = mux_select_reg;
    if (scan_mode)
    begin
      // an empty mask gives nothing to scan
      first_ok = !first_masked[4];
      first_chan = first_masked[3:0];
    end
    else if (mode == CSSS_MODE_CONT_RANGE)
    begin
      first_chan = scan_first_reg;
    end
  end

  // ==================================================
  // channel that follows a finished conversion
  logic cont_ok;
  logic [3:0] cont_chan;

  always_comb
  begin
    cont_ok = 1'b0;
    cont_chan = conv_channel_reg;
    unique case (mode)
      CSSS_MODE_SINGLE_SCAN:
      begin
        // one pass, stop after the last masked channel
        cont_ok = masking && !next_masked[4];
        cont_chan = next_masked[3:0];
      end
      CSSS_MODE_CONT_MUX:
      begin
        cont_ok = 1'b1;
        cont_chan = mux_select_reg;
      end
      CSSS_MODE_CONT_RANGE:
      begin
        if (masking)
        begin
          cont_ok = !wrap_masked[4];
          cont_chan = wrap_masked[3:0];
        end
        else
        begin
          cont_ok = 1'b1;
          cont_chan = (conv_channel_reg == scan_last_reg) ? scan_first_reg : conv_channel_reg + 4'h1;
        end
      end
      default:
      begin
        cont_ok = 1'b0;
      end
    endcase
  end

  // ==================================================
  // conversion sequencer
  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg <= CSSS_ST_IDLE;
      conv_start_reg <= 1'b0;
      conv_channel_reg <= `CSSS_RST_CHAN;
    end
    else
    begin
      conv_start_reg <= 1'b0;
      unique case (state_reg)
        CSSS_ST_IDLE:
        begin
          if (trigger && first_ok)
          begin
            state_reg <= CSSS_ST_CONV;
            conv_start_reg <= 1'b1;
            conv_channel_reg <= first_chan;
          end
        end
        CSSS_ST_CONV:
        begin
          if (conv_done)
          begin
            if (cont_ok)
            begin
              conv_start_reg <= 1'b1;
              conv_channel_reg <= cont_chan;
            end
            else
            begin
              state_reg <= CSSS_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==================================================
  // run start and run end events
  logic run_start;
  logic run_end;

  assign run_start = (state_reg == CSSS_ST_IDLE) && trigger && first_ok;
  assign run_end = (state_reg == CSSS_ST_CONV) && conv_done && !cont_ok;

  // ==================================================
  // busy flag, own flop so the output is registered
  logic conv_busy_reg;

  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      conv_busy_reg <= 1'b0;
    end
    else if (run_start)
    begin
      conv_busy_reg <= 1'b1;
    end
    else if (run_end)
    begin
      conv_busy_reg <= 1'b0;
    end
  end

  // ==================================================
  // read data, one cycle after the read strobe
  logic [7:0] rd_data_reg;
  logic [7:0] rd_next;

  always_comb
  begin
    rd_next = 8'h00;
    unique case (bus_req.addr)
      `CSSS_OFS_CONFIG: rd_next = {config_reg.scan_mask_enable, config_reg.start_mode_select,
                                   1'b0, config_reg.accum_select};
      `CSSS_OFS_CONTROL: rd_next = 8'(conv_busy_reg) << `CSSS_BUSY_BIT;
      `CSSS_OFS_MASK_LOW: rd_next = mask_low_reg;
      `CSSS_OFS_MASK_HIGH: rd_next = mask_high_reg;
      `CSSS_OFS_MUX_SELECT: rd_next = {4'h0, mux_select_reg};
      `CSSS_OFS_SCAN_FIRST: rd_next = {4'h0, scan_first_reg};
      `CSSS_OFS_SCAN_LAST: rd_next = {4'h0, scan_last_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      rd_data_reg <= `CSSS_RST_RDATA;
    end
    else
    begin
      rd_data_reg <= bus_req.rd ? rd_next : 8'h00;
    end
  end

  // ==================================================
  // outputs
  assign rd_data = rd_data_reg;
  assign conv_start = conv_start_reg;
  assign conv_channel = conv_channel_reg;
  assign conv_busy = conv_busy_reg;

endmodule // csss_top

// file: tb/csss_asserts.sv
// checker for the scan start selector ports
`timescale 1ns/1ps
`include "csss_regs.svh"
module csss_asserts #(
  parameter int NUM_CH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire csss_pkg::csss_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] timer_ovf,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic conv_busy
);
  import csss_pkg::*;
  // =====
  // shadow of mode and mux select
  logic [7:0] cfg_reg;
  logic [3:0] mux_reg;
  logic [2:0] md;
  logic [1:0] tix;
  logic sw1;
  assign md = cfg_reg[6:4];
  assign tix = (md == 3'h1) ? 2'h0 : (md == 3'h2) ? 2'h2 : (md == 3'h3) ? 2'h1 : 2'h3;
  assign sw1 = bus_req.wr && bus_req.addr == `CSSS_OFS_CONTROL && bus_req.wdata[`CSSS_BUSY_BIT];
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) cfg_reg <= 8'h00;
    else if (bus_req.wr && bus_req.addr == `CSSS_OFS_CONFIG) cfg_reg <= bus_req.wdata;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) mux_reg <= 4'h0;
    else if (bus_req.wr && bus_req.addr == `CSSS_OFS_MUX_SELECT) mux_reg <= bus_req.wdata[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // =====
  // properties
  a_start_pulse: assert property (conv_start |=> !conv_start) else $error("start longer than one cycle");
  a_start_busy: assert property (conv_start |-> conv_busy) else $error("start without busy");
  a_sw_start: assert property (!conv_busy && sw1 && (md == 3'h0 || md == 3'h6 || (md == 3'h7 && !cfg_reg[7]))
    |=> conv_start) else $error("busy write did not start");
  a_zero_write: assert property (!conv_busy && bus_req.wr && bus_req.addr == `CSSS_OFS_CONTROL
    && !bus_req.wdata[4] && timer_ovf == 4'h0 |=> !conv_start) else $error("zero write started");
  a_timer_start: assert property (!conv_busy && md inside {[3'h1:3'h4]} && timer_ovf[tix] |=> conv_start)
    else $error("timer overflow missed");
  a_timer_other: assert property (!conv_busy && md inside {[3'h1:3'h4]} && !timer_ovf[tix] |=> !conv_start)
    else $error("wrong source started");
  a_reserved_quiet: assert property (!conv_busy && md == 3'h5 && !cfg_reg[7] |=> !conv_start)
    else $error("reserved mode started");
  a_mux_channel: assert property (conv_start && $past(md) == 3'h6 |-> conv_channel == $past(mux_reg))
    else $error("wrong mux channel");
  a_single_idle: assert property (conv_done && conv_busy && md inside {[3'h0:3'h4]} |=> !conv_busy)
    else $error("single conversion kept busy");
  a_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00) else $error("read data outside slot");
  a_unmapped_rd: assert property (bus_req.rd && bus_req.addr == 3'h7 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_busy_read: assert property (bus_req.rd && bus_req.addr == `CSSS_OFS_CONTROL
    |=> rd_data == {3'h0, $past(conv_busy), 4'h0}) else $error("busy bit read wrong");
  c_timer: cover property (!conv_busy && timer_ovf != 4'h0 ##1 conv_start);
  c_scan: cover property (conv_start && md == 3'h5 && cfg_reg[7]);
  c_repeat: cover property (conv_done && conv_busy ##1 conv_start);
endmodule // csss_asserts
bind csss_top csss_asserts #(.NUM_CH(NUM_CH)) i_csss_asserts (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .rd_data(rd_data), .timer_ovf(timer_ovf), .conv_done(conv_done), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_busy(conv_busy));

// file: tb/tb_top.sv
// self-checking bench for the scan start selector
`timescale 1ns/1ps
module tb_top;
  import csss_pkg::*;
  logic clk, rst_b, conv_done, conv_start, conv_busy;
  logic [3:0] timer_ovf, conv_channel, mux, ch, l;
  logic [7:0] rd_data;
  logic [15:0] msk;
  csss_bus_req_t bus_req;
  int err_count, n_tests, cyc, seed, t;
  int q[$];
  csss_top #(.NUM_CH(16)) i_csss_top (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .timer_ovf(timer_ovf), .conv_done(conv_done), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_busy(conv_busy));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====
  // tasks
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    #1 chk("rd_data", e, rd_data);
  endtask
  task automatic tick(logic [3:0] v);
    @(posedge clk) timer_ovf <= v;
    @(posedge clk) timer_ovf <= 4'h0;
  endtask
  task automatic none;
    repeat (3)
    begin
      #1 chk("conv_start", 8'h00, {7'h0, conv_start});
      @(posedge clk);
    end
  endtask
  // model queue q holds the expected channel order
  task automatic run(logic stop, string nm);
    foreach (q[i])
    begin
      #1 chk("conv_start", 8'h01, {7'h0, conv_start});
      chk("conv_channel", 8'(q[i]), {4'h0, conv_channel});
      if (stop && i == q.size() - 1)
      begin
        rd(3'h1, 8'h10);
        wr(3'h0, 8'h00);
      end
      @(posedge clk) conv_done <= 1'b1;
      @(posedge clk) conv_done <= 1'b0;
    end
    #1 chk("conv_busy", 8'h00, {7'h0, conv_busy});
    q = {};
    $display("test %s done", nm);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end
  // =====
  // main sequence
  initial
  begin
    seed = 32'h4ff1e4ef;
    rst_b = 1'b0;
    conv_done = 1'b0;
    timer_ovf = 4'h0;
    bus_req = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'hFF);
    rd(3'h0, 8'hF7);
    wr(3'h7, 8'hAA);
    rd(3'h7, 8'h00);
    rd(3'h2, 8'h00);
    rd(3'h1, 8'h00);
    mux = 4'($random(seed));
    wr(3'h4, {4'h0, mux});
    rd(3'h4, {4'h0, mux});
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    none;
    wr(3'h1, 8'h10);
    q.push_back(mux);
    run(1'b0, "software start");
    for (int m = 1; m < 5; m++)
    begin
      t = (m == 1) ? 0 : (m == 2) ? 2 : (m == 3) ? 1 : 3;
      wr(3'h0, {1'b0, 3'(m), 4'h0});
      tick(~(4'h1 << t));
      none;
      wr(3'h1, 8'h10);
      none;
      tick(4'h1 << t);
      q.push_back(mux);
      run(1'b0, "timer start");
    end
    wr(3'h0, 8'h50);
    tick(4'hF);
    none;
    wr(3'h1, 8'h10);
    none;
    wr(3'h0, 8'h60);
    wr(3'h1, 8'h10);
    q = '{mux, mux, mux};
    run(1'b1, "continuous mux");
    ch = 4'($random(seed));
    l = 4'($random(seed));
    wr(3'h5, {4'h0, ch});
    wr(3'h6, {4'h0, l});
    wr(3'h2, 8'($random(seed)));
    wr(3'h0, 8'h70);
    wr(3'h1, 8'h10);
    for (int k = 0; k < 20; k++)
    begin
      q.push_back(ch);
      ch = (ch == l) ? 4'($signed(q[0])) : ch + 4'h1;
    end
    run(1'b1, "range scan");
    msk = 16'($random(seed)) | 16'h0100;
    wr(3'h2, msk[7:0]);
    wr(3'h3, msk[15:8]);
    wr(3'h0, 8'hD0);
    wr(3'h1, 8'h10);
    for (int c = 0; c < 16; c++) if (msk[c]) q.push_back(c);
    run(1'b0, "single scan");
    wr(3'h0, 8'hF0);
    wr(3'h1, 8'h10);
    for (int c = 0; c < 32; c++) if (msk[c % 16]) q.push_back(c % 16);
    run(1'b1, "auto scan");
    tally_and_finish;
  end
endmodule // tb_top
